// File: rtl/rx_path_power_control.sv
// Receive-path power control: two 8-bit registers resolving seven enables.
// Assumes the register master and the modem request share sys_clk.
//
// The address-and-strobe port was chosen for this implementation.
`include "rx_power_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_path_power_control
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire rx_power_pkg::reg_req_s regReq,
	output logic [7:0]                 rdData,
	input  wire logic [6:0]            modemPowerReq,
	output logic [6:0]                 circuitEnable
);

	logic [7:0] rxPathPowerDown;
	logic [7:0] rxPathPowerUp;
	logic [7:0] next_rxPathPowerDown;
	logic [7:0] next_rxPathPowerUp;
	logic [7:0] next_rdData;
	logic [6:0] next_circuitEnable;

	// Register bit of each circuit, enable index 6 = low noise amp .. 0 = converter
	localparam int BIT_OF [7] = '{`RXP_BIT_LNA, `RXP_BIT_MIX, `RXP_BIT_BBAMP,
		`RXP_BIT_MIXBUF, `RXP_BIT_LPF, `RXP_BIT_VGA, `RXP_BIT_ADC};

	// Decode one bit pair into a mode
	function automatic rx_power_pkg::power_mode_e decodeMode(input logic offBit,
		input logic onBit);
		if (offBit && onBit)
			return rx_power_pkg::MODE_MODEM;
		else if (!offBit && onBit)
			return rx_power_pkg::MODE_FORCE_OFF;
		else
			return rx_power_pkg::MODE_FORCE_ON;
	endfunction

	// Register writes and read data; reserved bit 3 is stored as written
	always_comb
	begin
		next_rxPathPowerDown = rxPathPowerDown;
		next_rxPathPowerUp   = rxPathPowerUp;
		next_rdData          = `RXP_ZERO_DATA;
		if (regReq.wrStb && regReq.addr == `RXP_OFS_DOWN)
			next_rxPathPowerDown = regReq.wrData;
		if (regReq.wrStb && regReq.addr == `RXP_OFS_UP)
			next_rxPathPowerUp = regReq.wrData;
		if (regReq.rdStb && regReq.addr == `RXP_OFS_DOWN)
			next_rdData = rxPathPowerDown;
		else if (regReq.rdStb && regReq.addr == `RXP_OFS_UP)
			next_rdData = rxPathPowerUp;
	end

	// Resolve each circuit's enable; registered so outputs leave a flip-flop
	generate
		for (genvar i = 0; i < `RXP_CIRCUITS; i++)
		begin : g_circ
			rx_power_pkg::power_mode_e mode;
			assign mode = decodeMode(next_rxPathPowerDown[BIT_OF[6-i]],
				next_rxPathPowerUp[BIT_OF[6-i]]);
			always_comb
			begin
				unique case (mode)
					rx_power_pkg::MODE_MODEM:     next_circuitEnable[i] = modemPowerReq[i];
					rx_power_pkg::MODE_FORCE_OFF: next_circuitEnable[i] = 1'b0;
					rx_power_pkg::MODE_FORCE_ON:  next_circuitEnable[i] = 1'b1;
					default:                      next_circuitEnable[i] = 1'b0;
				endcase
			end
		end
	endgenerate

	// State registers; reset values force every circuit off
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rxPathPowerDown <= `RXP_RST_DOWN;
			rxPathPowerUp   <= `RXP_RST_UP;
			rdData          <= `RXP_ZERO_DATA;
			circuitEnable   <= `RXP_ZERO_EN;
		end
		else
		begin
			rxPathPowerDown <= next_rxPathPowerDown;
			rxPathPowerUp   <= next_rxPathPowerUp;
			rdData          <= next_rdData;
			circuitEnable   <= next_circuitEnable;
		end
	end

	// Forced-off circuit has its enable low one cycle after the write
	AST_FORCED_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		(!rxPathPowerDown[`RXP_BIT_LNA] && rxPathPowerUp[`RXP_BIT_LNA]) |-> !circuitEnable[6])
		else $error("low noise amp enabled while forced off");
	AST_FORCED_ON: assert property (@(posedge sys_clk) disable iff (rst)
		!rxPathPowerUp[`RXP_BIT_ADC] |-> circuitEnable[0])
		else $error("converter not enabled while forced on");
	AST_MODEM_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
		(rxPathPowerDown[`RXP_BIT_VGA] && rxPathPowerUp[`RXP_BIT_VGA])
		|-> circuitEnable[1] == $past(modemPowerReq[1]))
		else $error("gain amp not following modem");
	AST_MIX_BIT: assert property (@(posedge sys_clk) disable iff (rst)
		(!rxPathPowerDown[`RXP_BIT_MIX] && rxPathPowerUp[`RXP_BIT_MIX]) |-> !circuitEnable[5])
		else $error("mixer enabled while forced off");
	AST_BBAMP_BIT: assert property (@(posedge sys_clk) disable iff (rst)
		!rxPathPowerUp[`RXP_BIT_BBAMP] |-> circuitEnable[4])
		else $error("baseband amp not forced on");
	AST_MIXBUF_BIT: assert property (@(posedge sys_clk) disable iff (rst)
		(!rxPathPowerDown[`RXP_BIT_MIXBUF] && rxPathPowerUp[`RXP_BIT_MIXBUF]) |-> !circuitEnable[3])
		else $error("mixer buffer enabled while forced off");
	AST_LPF_BIT: assert property (@(posedge sys_clk) disable iff (rst)
		!rxPathPowerUp[`RXP_BIT_LPF] |-> circuitEnable[2])
		else $error("low-pass filter not forced on");
	AST_READBACK: assert property (@(posedge sys_clk) disable iff (rst)
		(regReq.rdStb && regReq.addr == `RXP_OFS_UP && !regReq.wrStb)
		|=> rdData == $past(rxPathPowerUp))
		else $error("power-up register read back wrong");

	// Checks below watch the registered state against the enables at the same edge.
	// The enables are computed from the next register values, so a write shows on
	// circuitEnable in the cycle right after its strobe, with no extra lag.
	// Modem-controlled enables carry the modem request of the previous cycle,
	// which is why the follow checks compare against $past of the request.
	// Reserved bit 3 is stored and read back but decodes to nothing, so no check
	// here ties it to an enable; software is trusted to keep it at its fixed value.
	// Every check is disabled while rst is high; the reset state itself is forced
	// off, so none of the modem antecedents can hold at the first edge after release.

	// Bit-pair patterns, one per resolved mode; the checks read like the mode table
	sequence sForcedOff(offBit, onBit);
		!offBit && onBit;
	endsequence

	sequence sForcedOn(onBit);
		!onBit;
	endsequence

	sequence sModem(offBit, onBit);
		offBit && onBit;
	endsequence

	// Low noise amplifier, enable 6
	AST_LNA_ON: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOn(rxPathPowerUp[`RXP_BIT_LNA])
		|-> circuitEnable[6])
		else $error("low noise amp not forced on");

	AST_LNA_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sModem(rxPathPowerDown[`RXP_BIT_LNA], rxPathPowerUp[`RXP_BIT_LNA])
		|-> circuitEnable[6] == $past(modemPowerReq[6]))
		else $error("low noise amp not following modem");

	// Receive mixer, enable 5
	AST_MIX_ON: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOn(rxPathPowerUp[`RXP_BIT_MIX])
		|-> circuitEnable[5])
		else $error("mixer not forced on");

	AST_MIX_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sModem(rxPathPowerDown[`RXP_BIT_MIX], rxPathPowerUp[`RXP_BIT_MIX])
		|-> circuitEnable[5] == $past(modemPowerReq[5]))
		else $error("mixer not following modem");

	// Baseband amplifier, enable 4
	AST_BBAMP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOff(rxPathPowerDown[`RXP_BIT_BBAMP], rxPathPowerUp[`RXP_BIT_BBAMP])
		|-> !circuitEnable[4])
		else $error("baseband amp enabled while forced off");

	AST_BBAMP_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sModem(rxPathPowerDown[`RXP_BIT_BBAMP], rxPathPowerUp[`RXP_BIT_BBAMP])
		|-> circuitEnable[4] == $past(modemPowerReq[4]))
		else $error("baseband amp not following modem");

	// Mixer buffer, enable 3
	AST_MIXBUF_ON: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOn(rxPathPowerUp[`RXP_BIT_MIXBUF])
		|-> circuitEnable[3])
		else $error("mixer buffer not forced on");

	AST_MIXBUF_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sModem(rxPathPowerDown[`RXP_BIT_MIXBUF], rxPathPowerUp[`RXP_BIT_MIXBUF])
		|-> circuitEnable[3] == $past(modemPowerReq[3]))
		else $error("mixer buffer not following modem");

	// Low-pass filter, enable 2
	AST_LPF_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOff(rxPathPowerDown[`RXP_BIT_LPF], rxPathPowerUp[`RXP_BIT_LPF])
		|-> !circuitEnable[2])
		else $error("low-pass filter enabled while forced off");

	AST_LPF_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sModem(rxPathPowerDown[`RXP_BIT_LPF], rxPathPowerUp[`RXP_BIT_LPF])
		|-> circuitEnable[2] == $past(modemPowerReq[2]))
		else $error("low-pass filter not following modem");

	// Gain amplifier, enable 1
	AST_VGA_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOff(rxPathPowerDown[`RXP_BIT_VGA], rxPathPowerUp[`RXP_BIT_VGA])
		|-> !circuitEnable[1])
		else $error("gain amp enabled while forced off");

	AST_VGA_ON: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOn(rxPathPowerUp[`RXP_BIT_VGA])
		|-> circuitEnable[1])
		else $error("gain amp not forced on");

	// Receive converter, enable 0
	AST_ADC_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		sForcedOff(rxPathPowerDown[`RXP_BIT_ADC], rxPathPowerUp[`RXP_BIT_ADC])
		|-> !circuitEnable[0])
		else $error("converter enabled while forced off");

	AST_ADC_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sModem(rxPathPowerDown[`RXP_BIT_ADC], rxPathPowerUp[`RXP_BIT_ADC])
		|-> circuitEnable[0] == $past(modemPowerReq[0]))
		else $error("converter not following modem");

	// Register port: reads answer exactly one cycle later, writes land one cycle after the strobe
	AST_READBACK_DOWN: assert property (@(posedge sys_clk) disable iff (rst)
		(regReq.rdStb && regReq.addr == `RXP_OFS_DOWN && !regReq.wrStb)
		|=> rdData == $past(rxPathPowerDown))
		else $error("power-down register read back wrong");

	AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
		(regReq.rdStb && regReq.addr != `RXP_OFS_DOWN && regReq.addr != `RXP_OFS_UP)
		|=> rdData == `RXP_ZERO_DATA)
		else $error("unmapped read returned data");

	AST_IDLE_RDDATA: assert property (@(posedge sys_clk) disable iff (rst)
		!regReq.rdStb |=> rdData == `RXP_ZERO_DATA)
		else $error("read data present without a read");

	AST_WRITE_DOWN: assert property (@(posedge sys_clk) disable iff (rst)
		(regReq.wrStb && regReq.addr == `RXP_OFS_DOWN)
		|=> rxPathPowerDown == $past(regReq.wrData))
		else $error("power-down write did not land");

	AST_WRITE_UP: assert property (@(posedge sys_clk) disable iff (rst)
		(regReq.wrStb && regReq.addr == `RXP_OFS_UP)
		|=> rxPathPowerUp == $past(regReq.wrData))
		else $error("power-up write did not land");

	// Registers only move on their own write; an unmapped write must not leak in
	AST_HOLD_DOWN: assert property (@(posedge sys_clk) disable iff (rst)
		!(regReq.wrStb && regReq.addr == `RXP_OFS_DOWN)
		|=> $stable(rxPathPowerDown))
		else $error("power-down register changed without a write");

	AST_HOLD_UP: assert property (@(posedge sys_clk) disable iff (rst)
		!(regReq.wrStb && regReq.addr == `RXP_OFS_UP)
		|=> $stable(rxPathPowerUp))
		else $error("power-up register changed without a write");

	// Write steps: the enable must change in the cycle right after the strobe
	sequence sUpWriteOff;
		regReq.wrStb && regReq.addr == `RXP_OFS_UP && regReq.wrData[`RXP_BIT_ADC]
			&& !rxPathPowerDown[`RXP_BIT_ADC];
	endsequence

	AST_WRITE_FORCES_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		sUpWriteOff |=> !circuitEnable[0])
		else $error("converter still enabled after forced-off write");

	sequence sUpWriteOn;
		regReq.wrStb && regReq.addr == `RXP_OFS_UP && !regReq.wrData[`RXP_BIT_MIX];
	endsequence

	AST_WRITE_FORCES_ON: assert property (@(posedge sys_clk) disable iff (rst)
		sUpWriteOn |=> circuitEnable[5])
		else $error("mixer not enabled after forced-on write");

	sequence sDownWriteModem;
		regReq.wrStb && regReq.addr == `RXP_OFS_DOWN && regReq.wrData[`RXP_BIT_LNA]
			&& rxPathPowerUp[`RXP_BIT_LNA];
	endsequence

	AST_WRITE_HANDS_TO_MODEM: assert property (@(posedge sys_clk) disable iff (rst)
		sDownWriteModem |=> circuitEnable[6] == $past(modemPowerReq[6]))
		else $error("low noise amp not handed to modem after write");

	// Read data is a one-cycle pulse; anything non-zero must trace back to a read
	AST_RDDATA_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		rdData != `RXP_ZERO_DATA |-> $past(regReq.rdStb))
		else $error("read data without a preceding read strobe");

endmodule

`default_nettype wire

// File: rtl/rx_power_consts.svh
// Constants for the receive-path power control register bank.
// Assumes an 8-bit register port with a 16-bit address on sys_clk.
`ifndef RX_POWER_CONSTS_SVH
`define RX_POWER_CONSTS_SVH

`define RXP_ADDR_W        16
`define RXP_DATA_W        8
`define RXP_CIRCUITS      7
`define RXP_OFS_DOWN      16'h2204
`define RXP_OFS_UP        16'h2205
`define RXP_RST_DOWN      8'h00
`define RXP_RST_UP        8'hFF
`define RXP_BIT_LNA       7
`define RXP_BIT_MIX       6
`define RXP_BIT_BBAMP     5
`define RXP_BIT_MIXBUF    4
`define RXP_BIT_LPF       2
`define RXP_BIT_VGA       1
`define RXP_BIT_ADC       0
`define RXP_ZERO_DATA     8'h00
`define RXP_ZERO_EN       7'h00

`endif

// File: rtl/rx_power_pkg.sv
// Types for the receive-path power control register bank.
// Assumes the constants header is compiled alongside.
package rx_power_pkg;

	// Resolved power mode of one circuit
	typedef enum logic [1:0] {
		MODE_FORCE_ON,
		MODE_FORCE_OFF,
		MODE_MODEM
	} power_mode_e;

	// Register port request from the processor
	typedef struct packed {
		logic        wrStb;
		logic        rdStb;
		logic [15:0] addr;
		logic [7:0]  wrData;
	} reg_req_s;

endpackage

// File: verification/test_rx_path_power_control.sv
// Testbench for the receive-path power control bank.
// Assumes the bench drives every port and the design holds its own assertions.
`timescale 1ns/1ps
`default_nettype none
module test_rx_path_power_control;
	logic                      sys_clk, rst;
	rx_power_pkg::reg_req_s    regReq;
	logic [7:0]                rdData, dn, up;
	logic [6:0]                modemPowerReq, circuitEnable;
	logic [15:0]               v, cs[4];
	int                        n_fail, cmp_count, seed, i;

	rx_path_power_control dut (.sys_clk(sys_clk), .rst(rst), .regReq(regReq),
		.rdData(rdData), .modemPowerReq(modemPowerReq), .circuitEnable(circuitEnable));

	// Clock at 125 MHz
	initial
	begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Expected enables; bits 7..4 and 2..0 map to enables 6..0, bit 3 skipped
	function automatic logic [6:0] exp_en(logic [7:0] d, logic [7:0] u, logic [6:0] m);
		int b;
		for (int k = 0; k < 7; k++)
		begin
			b = (k > 2) ? k + 1 : k;
			exp_en[k] = u[b] ? (d[b] & m[k]) : 1'b1;
		end
	endfunction

	task automatic chk(logic [7:0] got, logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One strobe cycle; read data lands in the following cycle only
	task automatic access(logic w, logic [15:0] a, logic [7:0] d);
		@(posedge sys_clk);
		regReq <= '{wrStb: w, rdStb: !w, addr: a, wrData: d};
		@(posedge sys_clk);
		regReq <= '0;
		#1;
	endtask

	task automatic wr(logic [15:0] a, logic [7:0] d);
		access(1'b1, a, d);
		if (a == 16'h2204) dn = d;
		if (a == 16'h2205) up = d;
	endtask

	task automatic rd(logic [15:0] a, logic [7:0] e);
		access(1'b0, a, 8'h00);
		chk(rdData, e);
	endtask

	// One extra edge lets the modem request pass its register
	task automatic check_all();
		@(posedge sys_clk);
		#1;
		chk({1'b0, circuitEnable}, {1'b0, exp_en(dn, up, modemPowerReq)});
		rd(16'h2204, dn);
		rd(16'h2205, up);
	endtask

	task automatic final_report();
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		{seed, n_fail, cmp_count} = {32'd90, 32'd0, 32'd0};
		{rst, regReq, modemPowerReq, dn, up} = {1'b1, 26'h0, 7'h00, 8'h00, 8'hFF};
		cs = '{16'hF7FF, 16'hF708, 16'h0008, 16'h00FF};
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk({1'b0, circuitEnable}, 8'h00);
		rd(16'h2204, 8'h00);
		rd(16'h2205, 8'hFF);
		wr(16'h2206, 8'h55);
		rd(16'h2206, 8'h00);
		// Corner modes first, then random pairs; reserved bit 3 kept fixed
		for (i = 0; i < 40; i++)
		begin
			@(posedge sys_clk);
			modemPowerReq <= 7'($random(seed));
			v = (i < 4) ? cs[i] : 16'($random(seed));
			wr(16'h2204, v[15:8] & 8'hF7);
			wr(16'h2205, v[7:0] | 8'h08);
			check_all();
		end
		final_report();
	end
endmodule
`default_nettype wire
